// ---- core/i2csa_core.sv ----
/*
 I2C slave: START/STOP detection, byte shifting, 7/10-bit address match,
 automatic acknowledge, receive buffer and status flags.
 Assumes SCL and SDA inputs are asynchronous pins; outputs are open-drain
 enables, low to pull the line low.
*/
`timescale 1ns/1ps
module i2csa_core
  import i2csa_pkg::*;
#(
  parameter int WIDTH = DATA_W
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic enable_i,
  input wire logic ten_bit_mode_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [WIDTH-1:0] slave_address_wr_data_i,
  input wire logic slave_address_wr_i,
  input wire logic [WIDTH-1:0] transmit_data_i,
  input wire logic transmit_load_i,
  input wire logic receive_buffer_rd_i,
  input wire logic overflow_clear_i,
  input wire logic irq_clear_i,
  output logic [WIDTH-1:0] receive_buffer_o,
  output logic [WIDTH-1:0] slave_address_o,
  output i2csa_pkg::i2csa_status_t serial_status_o,
  output logic serial_irq_flag_o
);
  import i2csa_pkg::*;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  i2csa_state_t state_reg;
  logic [WIDTH-1:0] serial_shift_reg;
  logic [WIDTH-1:0] receive_buffer_reg;
  logic [WIDTH-1:0] slave_address_reg;
  logic [WIDTH-1:0] tx_shift_reg;
  logic [3:0] bit_cnt_reg;
  logic buffer_full_flag_reg;
  logic receive_overflow_flag_reg;
  logic update_address_flag_reg;
  logic serial_irq_flag_reg;
  logic read_write_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic ack_drive_reg;
  logic tx_drive_reg;
  logic hold_scl_reg;
  logic high_matched_reg;
  logic tx_pending_reg;
  logic byte_done;
  logic addr_match7;
  logic addr_match_hi;
  logic addr_match_lo;
  logic can_accept;
  logic accept_byte;
  logic ack_phase_end;

  // Two-stage synchronisers for the bus pins
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (clk_en_i)
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_rise = scl_sync_reg[1] && !scl_prev_reg;
  assign scl_fall = !scl_sync_reg[1] && scl_prev_reg;
  assign start_det = enable_i && scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
  assign stop_det = enable_i && scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];

  // Eighth falling edge ends the byte, ninth ends acknowledge
  assign byte_done = scl_fall && (bit_cnt_reg == ACK_BIT_COUNT);
  assign ack_phase_end = scl_fall && (bit_cnt_reg == LAST_BIT_COUNT);
  assign addr_match7 = (serial_shift_reg[7:1] == slave_address_reg[7:1]);
  assign addr_match_hi = (serial_shift_reg[7:3] == TEN_BIT_PREFIX)
    && (serial_shift_reg[2:1] == slave_address_reg[2:1]);
  assign addr_match_lo = (serial_shift_reg == slave_address_reg);
  assign can_accept = !buffer_full_flag_reg && !receive_overflow_flag_reg;
  // General call is not decoded separately; address 0 matches only when slave_address_reg[7:1] is zero
  always_comb
  begin
    accept_byte = 1'b0;
    unique case (state_reg)
      ST_IDLE: accept_byte = 1'b0;
      ST_ADDR:
      begin
        if (ten_bit_mode_i)
          accept_byte = addr_match_hi && (!serial_shift_reg[0] || high_matched_reg);
        else
          accept_byte = addr_match7;
      end
      ST_ADDR_LOW: accept_byte = addr_match_lo;
      ST_RECV: accept_byte = 1'b1;
      ST_XMIT: accept_byte = 1'b0;
    endcase
  end

  // Bit counter and shift register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bit_cnt_reg <= 4'h0;
      serial_shift_reg <= BUF_RESET;
    end
    else if (clk_en_i)
    begin
      if (start_det)
        bit_cnt_reg <= 4'h0;
      else if (scl_rise && bit_cnt_reg < LAST_BIT_COUNT)
      begin
        serial_shift_reg <= {serial_shift_reg[WIDTH-2:0], sda_sync_reg[1]};
      end
      else if (scl_fall)
        bit_cnt_reg <= (bit_cnt_reg == LAST_BIT_COUNT) ? 4'h1 : bit_cnt_reg + 4'h1;
    end
  end

  // Protocol state
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ST_IDLE;
      read_write_reg <= 1'b0;
      high_matched_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!enable_i || stop_det)
      begin
        state_reg <= ST_IDLE;
        if (!enable_i)
          high_matched_reg <= 1'b0;
      end
      else if (start_det)
        state_reg <= ST_ADDR;
      else if (byte_done)
      begin
        unique case (state_reg)
          ST_IDLE: state_reg <= ST_IDLE;
          ST_ADDR:
          begin
            read_write_reg <= serial_shift_reg[0];
            if (!accept_byte)
            begin
              state_reg <= ST_IDLE;
              high_matched_reg <= 1'b0;
            end
            else if (serial_shift_reg[0])
              state_reg <= ST_XMIT;
            else if (ten_bit_mode_i)
              state_reg <= ST_ADDR_LOW;
            else
              state_reg <= ST_RECV;
          end
          ST_ADDR_LOW:
          begin
            high_matched_reg <= accept_byte;
            state_reg <= accept_byte ? ST_RECV : ST_IDLE;
          end
          ST_RECV: state_reg <= ST_RECV;
          ST_XMIT: state_reg <= ST_XMIT;
        endcase
      end
      else if (ack_phase_end && state_reg == ST_XMIT && sda_sync_reg[1])
        state_reg <= ST_IDLE;
    end
  end

  // Receive buffer, flags and acknowledge
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      receive_buffer_reg <= BUF_RESET;
      buffer_full_flag_reg <= 1'b0;
      receive_overflow_flag_reg <= 1'b0;
      serial_irq_flag_reg <= 1'b0;
      update_address_flag_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      slave_address_reg <= ADDR_RESET;
    end
    else if (clk_en_i)
    begin
      if (receive_buffer_rd_i)
        buffer_full_flag_reg <= 1'b0;
      if (overflow_clear_i)
        receive_overflow_flag_reg <= 1'b0;
      if (irq_clear_i)
        serial_irq_flag_reg <= 1'b0;
      if (slave_address_wr_i)
      begin
        slave_address_reg <= slave_address_wr_data_i;
        update_address_flag_reg <= 1'b0;
      end
      if (byte_done && accept_byte)
      begin
        if (can_accept)
        begin
          receive_buffer_reg <= serial_shift_reg;
          buffer_full_flag_reg <= 1'b1;
          ack_drive_reg <= !(state_reg == ST_XMIT);
          if (ten_bit_mode_i && ((state_reg == ST_ADDR && !serial_shift_reg[0])
            || state_reg == ST_ADDR_LOW))
          begin
            update_address_flag_reg <= 1'b1;
          end
        end
        else if (state_reg == ST_RECV)
          receive_overflow_flag_reg <= 1'b1;
      end
      if (ack_phase_end)
      begin
        ack_drive_reg <= 1'b0;
        if (state_reg != ST_IDLE || ack_drive_reg)
          serial_irq_flag_reg <= 1'b1;
      end
      if (start_det || stop_det)
        ack_drive_reg <= 1'b0;
      if (!enable_i)
        ack_drive_reg <= 1'b0;
    end
  end

  // Clock held from the ninth fall, so ack and irq complete first
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hold_scl_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (slave_address_wr_i || !enable_i)
        hold_scl_reg <= 1'b0;
      else if (ack_phase_end && update_address_flag_reg)
        hold_scl_reg <= 1'b1;
    end
  end

  // Transmit shifter, sets SDA drive on SCL falling edges and holds it through SCL high
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_shift_reg <= BUF_RESET;
      tx_drive_reg <= 1'b0;
      tx_pending_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (transmit_load_i)
      begin
        tx_shift_reg <= transmit_data_i;
        tx_pending_reg <= 1'b1;
      end
      else if (state_reg == ST_XMIT && scl_fall)
      begin
        if (ack_phase_end || byte_done)
          tx_drive_reg <= 1'b0;
        if (bit_cnt_reg == LAST_BIT_COUNT && tx_pending_reg)
        begin
          tx_drive_reg <= !tx_shift_reg[WIDTH-1];
          tx_pending_reg <= 1'b0;
        end
        else if (bit_cnt_reg < ACK_BIT_COUNT && bit_cnt_reg != 4'h0)
        begin
          tx_drive_reg <= !tx_shift_reg[WIDTH-2];
          tx_shift_reg <= {tx_shift_reg[WIDTH-2:0], 1'b0};
        end
      end
      if (state_reg != ST_XMIT)
        tx_drive_reg <= 1'b0;
    end
  end

  // START and STOP status bits
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (start_det)
      begin
        start_seen_reg <= 1'b1;
        stop_seen_reg <= 1'b0;
      end
      else if (stop_det)
      begin
        stop_seen_reg <= 1'b1;
        start_seen_reg <= 1'b0;
      end
    end
  end

  // Open-drain outputs: only pull low or release
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = !hold_scl_reg;
  assign sda_oe_n_o = !(ack_drive_reg || tx_drive_reg);
  assign receive_buffer_o = receive_buffer_reg;
  assign slave_address_o = slave_address_reg;
  assign serial_irq_flag_o = serial_irq_flag_reg;
  assign serial_status_o = '{buffer_full_flag: buffer_full_flag_reg,
    receive_overflow_flag: receive_overflow_flag_reg,
    update_address_flag: update_address_flag_reg,
    read_write: read_write_reg,
    start_seen: start_seen_reg,
    stop_seen: stop_seen_reg};
endmodule

// ---- inc/i2csa_pkg.sv ----
/*
 Constants and carrier types for the I2C slave address/receive block.
 Assumes a 200 MHz core clock and an open-drain bus resolved outside.
*/
// Summary of operation
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - SDA changes only while SCL low
// - Bus lines only pulled low or released
// - Slave overrides pin input when transmitting
// - Auto acknowledge and shift register to buffer on the same edge
// - Full or overflow: no ack, no load, irq
// - Buffer read clears full; overflow cleared by software
// - After START shift in eight bits
// - Sample data on SCL rising edge
// - Compare upper seven bits at eighth falling edge
// - Match: load, set full, ack, irq ninth fall
// - Ten-bit first byte is 11110 A9 A8 RW
// - High byte: set flags, hold SCL until reload
// - Low byte: set flags, hold until high reload
// - Ten-bit read after restart sets irq and full
// - Whole slave protocol in hardware, no general call
// - Standard mode up to 100 Kbps only
package i2csa_pkg;
  localparam int DATA_W = 8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [3:0] ACK_BIT_COUNT = 4'h8;
  localparam logic [3:0] LAST_BIT_COUNT = 4'h9;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCL_MIN_PHASE_NS = 4000;
  localparam int SCL_MIN_PHASE_CYC = (SCL_MIN_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic update_address_flag;
    logic read_write;
    logic start_seen;
    logic stop_seen;
  } i2csa_status_t;

  typedef struct packed {
    logic scl_oe_n;
    logic sda_oe_n;
  } i2csa_drive_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ADDR_LOW = 5'h04,
    ST_RECV = 5'h08,
    ST_XMIT = 5'h10
  } i2csa_state_t;
endpackage

// ---- testbench/i2csa_core_asserts.sv ----
/*
 Checker for the I2C slave core ports.
 Assumes one core clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module i2csa_core_asserts
  import i2csa_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic receive_buffer_rd_i,
  input wire logic overflow_clear_i,
  input wire logic irq_clear_i,
  input wire logic [7:0] receive_buffer_o,
  input wire i2csa_pkg::i2csa_status_t serial_status_o,
  input wire logic serial_irq_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ack_hold; !sda_oe_n_o [*8]; endsequence
  property p_drain; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("bus output not open drain");
  property p_ack_len; $fell(sda_oe_n_o) |-> s_ack_hold; endproperty
  a_ack_len: assert property (p_ack_len) else $error("data pull-down too short");
  property p_sda_change; $changed(sda_oe_n_o) |-> !scl_i; endproperty
  a_sda_change: assert property (p_sda_change) else $error("data changed with clock high");
  property p_buf_load; $changed(receive_buffer_o) |-> $rose(serial_status_o.buffer_full_flag); endproperty
  a_buf_load: assert property (p_buf_load) else $error("buffer loaded without full");
  property p_full_irq; $rose(serial_status_o.buffer_full_flag) |-> ##[0:60] serial_irq_flag_o; endproperty
  a_full_irq: assert property (p_full_irq) else $error("no irq after byte");
  property p_full_clr; receive_buffer_rd_i |=> !serial_status_o.buffer_full_flag; endproperty
  a_full_clr: assert property (p_full_clr) else $error("read did not clear full");
  property p_ovf_keep; serial_status_o.receive_overflow_flag && !overflow_clear_i |=>
    serial_status_o.receive_overflow_flag; endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow cleared alone");
  property p_irq_keep; serial_irq_flag_o && !irq_clear_i |=> serial_irq_flag_o; endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("irq flag cleared alone");
  property p_hold; $fell(scl_oe_n_o) |-> serial_status_o.update_address_flag; endproperty
  a_hold: assert property (p_hold) else $error("clock held without update flag");
endmodule
bind i2csa_core i2csa_core_asserts u_asserts (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
  .scl_o(scl_o), .sda_o(sda_o), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o),
  .receive_buffer_rd_i(receive_buffer_rd_i), .overflow_clear_i(overflow_clear_i),
  .irq_clear_i(irq_clear_i), .receive_buffer_o(receive_buffer_o),
  .serial_status_o(serial_status_o), .serial_irq_flag_o(serial_irq_flag_o));

// ---- testbench/i2csa_master_model.sv ----
/*
 Behavioural I2C bus master, 160 ns bit clock, honours clock holds.
 Assumes both lines resolved as wired-AND with pull-ups.
*/
`timescale 1ns/1ps
module i2csa_master_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_n_o,
  output logic sda_oe_n_o
);
  initial
  begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // One clock pulse, data set up while clock low
  task automatic pulse(input logic b, output logic seen);
    sda_oe_n_o = b;
    #40;
    scl_oe_n_o = 1'b1;
    wait (scl_i);
    #40;
    seen = sda_i;
    #40;
    scl_oe_n_o = 1'b0;
    #40;
  endtask
  task automatic start();
    sda_oe_n_o = 1'b1;
    #40;
    scl_oe_n_o = 1'b1;
    wait (scl_i);
    #40;
    sda_oe_n_o = 1'b0;
    #80;
    scl_oe_n_o = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_oe_n_o = 1'b0;
    #40;
    scl_oe_n_o = 1'b1;
    wait (scl_i);
    #40;
    sda_oe_n_o = 1'b1;
    #80;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(1'b1, b[i]);
    pulse(nack, s);
  endtask
endmodule

// ---- testbench/testbench.sv ----
/*
 Bench: master model traffic plus software strobes, with compares.
 Assumes 5 ns core clock and pull-ups on both bus lines.
*/
`timescale 1ns/1ps
module testbench;
  import i2csa_pkg::*;
  logic clk_i, reset_n_i, ten_bit, ack, scl_m, sda_m, scl_d, sda_d;
  logic [3:0] sw;
  logic [7:0] wr_data, rd_data, tx_data, rx_data;
  logic tx_load;
  i2csa_status_t st;
  logic irq;
  int mismatches, comparisons;
  wire logic scl_line = scl_m & scl_d;
  wire logic sda_line = sda_m & sda_d;
  i2csa_core u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .enable_i(1'b1),
    .ten_bit_mode_i(ten_bit), .scl_i(scl_line), .sda_i(sda_line), .scl_o(), .scl_oe_n_o(scl_d),
    .sda_o(), .sda_oe_n_o(sda_d), .slave_address_wr_data_i(wr_data), .slave_address_wr_i(sw[3]),
    .transmit_data_i(tx_data), .transmit_load_i(tx_load), .receive_buffer_rd_i(sw[2]),
    .overflow_clear_i(sw[1]), .irq_clear_i(sw[0]), .receive_buffer_o(rd_data),
    .slave_address_o(), .serial_status_o(st), .serial_irq_flag_o(irq));
  i2csa_master_model u_master (.scl_i(scl_line), .sda_i(sda_line), .scl_oe_n_o(scl_m), .sda_oe_n_o(sda_m));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected {full, overflow, update, irq} then buffer
  task automatic chk_state(input logic [11:0] exp);
    chk({st.buffer_full_flag, st.receive_overflow_flag, st.update_address_flag, irq, rd_data}, exp);
  endtask
  task automatic strobe(input logic [3:0] s, input logic [7:0] d);
    @(negedge clk_i);
    sw = s;
    wr_data = d;
    @(negedge clk_i);
    sw = 4'h0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic load_tx(input logic [7:0] d);
    @(negedge clk_i);
    tx_load = 1'b1;
    tx_data = d;
    @(negedge clk_i);
    tx_load = 1'b0;
  endtask
  task automatic frame_byte(input logic [7:0] b, input logic exp_ack);
    u_master.wr_byte(b, ack);
    chk(ack, exp_ack);
    repeat (8) @(negedge clk_i);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    reset_n_i = 1'b0;
    ten_bit = 1'b0;
    sw = 4'h0;
    wr_data = 8'h00;
    tx_load = 1'b0;
    tx_data = 8'h00;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_state(12'h000);
    chk({scl_d, sda_d}, 2'h3);
    strobe(4'h8, 8'ha4);
    u_master.start();
    frame_byte(8'ha4, 1'b0);
    chk_state(12'h9a4);
    frame_byte(8'h3c, 1'b1);
    chk_state(12'hda4);
    strobe(4'h1, 8'h00);
    strobe(4'h4, 8'h00);
    chk_state(12'h4a4);
    frame_byte(8'h5a, 1'b1);
    chk_state(12'h5a4);
    strobe(4'h3, 8'h00);
    chk_state(12'h0a4);
    frame_byte(8'h77, 1'b0);
    chk_state(12'h977);
    u_master.stop();
    chk(st.stop_seen, 1'b1);
    strobe(4'h5, 8'h00);
    u_master.start();
    frame_byte(8'h40, 1'b1);
    chk_state(12'h077);
    u_master.stop();
    load_tx(8'h96);
    u_master.start();
    frame_byte(8'ha5, 1'b0);
    chk({st.read_write, st.start_seen}, 2'h3);
    u_master.rd_byte(1'b1, rx_data);
    chk(rx_data, 8'h96);
    chk_state(12'h9a5);
    u_master.stop();
    strobe(4'h5, 8'h00);
    ten_bit = 1'b1;
    strobe(4'h8, 8'hf2);
    u_master.start();
    frame_byte(8'hf2, 1'b0);
    chk_state(12'hbf2);
    chk(scl_d, 1'b0);
    strobe(4'h8, 8'h5b);
    chk({st.update_address_flag, scl_d}, 2'h1);
    strobe(4'h5, 8'h00);
    frame_byte(8'h5b, 1'b0);
    chk_state(12'hb5b);
    chk(scl_d, 1'b0);
    strobe(4'h8, 8'hf2);
    chk({st.update_address_flag, scl_d}, 2'h1);
    strobe(4'h5, 8'h00);
    frame_byte(8'h99, 1'b0);
    chk_state(12'h999);
    strobe(4'h5, 8'h00);
    load_tx(8'h3c);
    u_master.start();
    frame_byte(8'hf3, 1'b0);
    chk_state(12'h9f3);
    u_master.rd_byte(1'b1, rx_data);
    chk(rx_data, 8'h3c);
    u_master.stop();
    give_verdict();
  end
endmodule
